// >>> sideband_pkg.sv
// Shared constants and types for the processor sideband control block.
// Assumes a single 50 MHz bus clock and a synchronous active-high reset.
package sideband_pkg;

  localparam int CLK_PERIOD_NS = 20;
  // Power-on reset hold the system must give, in microseconds
  localparam int POR_HOLD_US = 2000;
  localparam int POR_HOLD_CYCLES = (POR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Outputs must drop within this many bus clocks of seeing reset
  localparam int RESET_DROP_CLOCKS = 2;
  localparam int REQ_CMD_WIDTH = 5;
  localparam logic [4:0] REQ_CMD_IDLE = 5'h00;
  localparam logic [4:0] REQ_CMD_HALT = 5'h11;
  localparam logic [4:0] REQ_CMD_LOCKED = 5'h0A;
  localparam int SYNC_COUNT = 11;
  // Arbitrary identification value, not tied to any part
  localparam logic [15:0] DEVICE_SIGNATURE = 16'h0ABC;

  typedef enum logic [1:0] {
    LOCK_IDLE,
    LOCK_HOLD,
    LOCK_WAIT_END
  } lock_state_type;

endpackage : sideband_pkg

// >>> sync_bank.sv
// Two-flop synchronisers for a bank of asynchronous inputs.
// Assumes all inputs are levels; a pulse narrower than one clock may be lost.
// No reset here: a strap held through reset must show on the first edge after release.
`timescale 1ns/10ps
module sync_bank #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // Bus clock
  input wire logic [WIDTH-1:0] async_in, // Pins from outside
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        meta_d[i] = async_in[i];
        sync_d[i] = meta_q[i];
      end
    end
  endgenerate

  // Clearing these in reset would hide the soft-init strap at reset release
  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;

endmodule : sync_bank

// >>> sideband_control.sv
// Sideband control, error, interrupt, lock and reset signalling toward the chipset.
// Assumes core events arrive as same-clock levels or pulses; pins are asynchronous.
//
// How it works
// - Unmasked FP error drives error/break when running
// - Break event held until stop-clock removed
// - Probe request during stop-clock is break event
// - Snoop stall drives hit and hit-modified together
// - Internal error sticky until reset or inits
// - Ignore-numeric-error continues; otherwise pending error faults
// - Numeric-error enable bit overrides ignore input
// - Soft init resets integer state, keeps caches
// - Snoops keep being serviced during soft init
// - Soft init at reset release starts self-test
// - Controller disabled: pins become maskable and nonmaskable
// - Local interrupt controller enabled after reset
// - Atomic hold spans whole locked sequence
// - Overtemperature output follows thermal monitor trip
// - Low-power indicator asserted in deepest sleep
// - Reset invalidates caches without writeback
// - Bus outputs dropped within two clocks of reset
// - Owner drives five request command lines
`timescale 1ns/10ps
module sideband_control
  import sideband_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic stop_clock_request, // Async pin, high = stop-clock asserted
  input wire logic probe_request, // Async pin, debug probe request
  input wire logic ignore_numeric_error, // Async pin
  input wire logic soft_init, // Async pin, soft initialisation
  input wire logic bus_init_request, // Async pin, bus init
  input wire logic [1:0] local_interrupt_pins, // Async pins
  input wire logic supply_stable_input, // Async pin, supplies good
  input wire logic priority_bus_request, // Async pin from priority agent
  input wire logic fp_error_detect, // Core: unmasked FP error level
  input wire logic fp_insn_noncontrol, // Core: noncontrol FP instruction issues
  input wire logic fp_error_pending, // Core: earlier FP instruction erred
  input wire logic numeric_error_enable_bit, // Core: control register zero bit
  input wire logic internal_error_event, // Core: internal error pulse
  input wire logic lic_enable_wr, // Core: write strobe for controller enable
  input wire logic lic_enable_val, // Core: new controller enable value
  input wire logic snoop_request, // Bus: snoop to service
  input wire logic snoop_stall_need, // Core: snoop result not ready
  input wire logic lock_begin, // Core: first locked transaction starts
  input wire logic lock_end, // Core: last locked transaction ends
  input wire logic txn_start, // Core: issue a transaction
  input wire logic [4:0] txn_cmd, // Core: transaction command
  input wire logic temp_max_trip, // Thermal monitor at max safe temperature
  input wire logic deep_sleep_state, // Power control: in deepest sleep
  output logic fp_error_break_event_out, // Shared error/break, high = asserted
  output logic internal_error_out, // High = internal error
  output logic snoop_hit, // Snoop hit
  output logic snoop_hit_modified, // Snoop hit modified
  output logic bus_atomic_hold, // Atomic lock hold
  output logic overtemperature_out, // High = overtemperature
  output logic low_power_status_indicator, // High = deepest sleep
  output logic [4:0] request_cmd, // Request command lines
  output logic request_valid, // Request command qualifier
  output logic fp_exception, // Core: raise FP exception pulse
  output logic maskable_interrupt_request, // Core: fallback maskable interrupt
  output logic nonmaskable_interrupt, // Core: fallback nonmaskable interrupt
  output logic [1:0] local_interrupt_out, // Core: pins in local interrupt role
  output logic integer_reset, // Core: reset integer regs, keep caches/FP
  output logic cache_invalidate, // Core: invalidate caches, no writeback
  output logic builtin_self_test, // Core: run self-test pulse
  output logic core_ready // Supplies stable and out of reset
);

  logic [SYNC_COUNT-1:0] async_raw;
  logic [SYNC_COUNT-1:0] async_sync;
  logic stop_clock_request_s;
  logic probe_request_s;
  logic ignore_numeric_error_s;
  logic init_s;
  logic bus_init_request_s;
  logic [1:0] lint_s;
  logic pgood_s;
  logic priority_bus_request_s;

  assign async_raw = {priority_bus_request_unused_tap(priority_bus_request), supply_stable_input,
                      local_interrupt_pins, bus_init_request, soft_init,
                      ignore_numeric_error, probe_request, stop_clock_request,
                      2'b00};

  function automatic logic priority_bus_request_unused_tap(input logic v);
    priority_bus_request_unused_tap = v;
  endfunction : priority_bus_request_unused_tap

  sync_bank #(
    .WIDTH(SYNC_COUNT)
  ) u_sync (
    .clk(clk),
    .async_in(async_raw),
    .sync_out(async_sync)
  );

  assign priority_bus_request_s = async_sync[10];
  assign pgood_s = async_sync[9];
  assign lint_s = async_sync[8:7];
  assign bus_init_request_s = async_sync[6];
  assign init_s = async_sync[5];
  assign ignore_numeric_error_s = async_sync[4];
  assign probe_request_s = async_sync[3];
  assign stop_clock_request_s = async_sync[2];

  // Error/break and error latch state
  logic break_q;
  logic break_d;
  logic internal_error_out_q;
  logic internal_error_out_d;
  logic ferr_q;
  logic ferr_d;
  logic fpexc_q;
  logic fpexc_d;

  always_comb
  begin
    break_d = break_q;
    if (!stop_clock_request_s)
      break_d = 1'b0;
    else if (fp_error_detect || probe_request_s)
      break_d = 1'b1;
    ferr_d = fp_error_detect && !stop_clock_request_s;
    // Set wins over clear so an error in the clearing cycle is not lost
    if (internal_error_event)
      internal_error_out_d = 1'b1;
    else if (bus_init_request_s || init_s)
      internal_error_out_d = 1'b0;
    else
      internal_error_out_d = internal_error_out_q;
    // Native error reporting bit makes the ignore pin irrelevant
    fpexc_d = fp_insn_noncontrol && fp_error_pending &&
              (numeric_error_enable_bit || !ignore_numeric_error_s);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      break_q <= 1'b0;
      internal_error_out_q <= 1'b0;
      ferr_q <= 1'b0;
      fpexc_q <= 1'b0;
    end
    else
    begin
      break_q <= break_d;
      internal_error_out_q <= internal_error_out_d;
      ferr_q <= ferr_d;
      fpexc_q <= fpexc_d;
    end
  end

  // Soft init, self-test strap and reset effects
  logic init_prev_q;
  logic init_prev_d;
  logic rst_prev_q;
  logic builtin_self_test_q;
  logic builtin_self_test_d;
  logic intrst_q;
  logic intrst_d;

  always_comb
  begin
    init_prev_d = init_s;
    // Strap caught by a clocked process on the first edge after release
    builtin_self_test_d = rst_prev_q && init_s;
    // A strap held high through reset is not a fresh soft init
    intrst_d = init_s && !init_prev_q && !rst_prev_q;
  end

  always_ff @(posedge clk)
  begin
    rst_prev_q <= rst;
    if (rst)
    begin
      init_prev_q <= 1'b0;
      builtin_self_test_q <= 1'b0;
      intrst_q <= 1'b0;
    end
    else
    begin
      init_prev_q <= init_prev_d;
      builtin_self_test_q <= builtin_self_test_d;
      intrst_q <= intrst_d;
    end
  end

  // Local interrupt controller enable and pin role
  logic lic_en_q;
  logic lic_en_d;

  always_comb
  begin
    lic_en_d = lic_enable_wr ? lic_enable_val : lic_en_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      lic_en_q <= 1'b1;
    else
      lic_en_q <= lic_en_d;
  end

  // Lock sequencing and request commands
  lock_state_type lock_q;
  lock_state_type lock_d;
  logic [4:0] cmd_q;
  logic [4:0] cmd_d;
  logic req_q;
  logic req_d;
  logic stall_q;
  logic stall_d;
  logic hot_q;
  logic psi_q;

  always_comb
  begin
    lock_d = lock_q;
    case (lock_q)
      LOCK_IDLE:
        if (lock_begin && txn_start)
          lock_d = LOCK_HOLD;
      LOCK_HOLD:
        if (lock_end)
          lock_d = LOCK_WAIT_END;
      LOCK_WAIT_END:
        lock_d = LOCK_IDLE;
      default:
        lock_d = LOCK_IDLE;
    endcase
    req_d = txn_start;
    cmd_d = txn_start ? txn_cmd : REQ_CMD_IDLE;
    if (internal_error_event)
    begin
      req_d = 1'b1;
      cmd_d = REQ_CMD_HALT;
    end
    // Stall stays serviced through soft init; both lines move together
    stall_d = snoop_request && snoop_stall_need;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_q <= LOCK_IDLE;
      cmd_q <= REQ_CMD_IDLE;
      req_q <= 1'b0;
      stall_q <= 1'b0;
      hot_q <= 1'b0;
      psi_q <= 1'b0;
    end
    else
    begin
      lock_q <= lock_d;
      cmd_q <= cmd_d;
      req_q <= req_d;
      stall_q <= stall_d;
      hot_q <= temp_max_trip;
      psi_q <= deep_sleep_state;
    end
  end

  // Bus outputs come from flops cleared by reset, so they drop in one clock
  assign fp_error_break_event_out = ferr_q || break_q;
  assign internal_error_out = internal_error_out_q;
  assign snoop_hit = stall_q;
  assign snoop_hit_modified = stall_q;
  assign bus_atomic_hold = (lock_q != LOCK_IDLE);
  assign overtemperature_out = hot_q;
  assign low_power_status_indicator = psi_q;
  assign request_cmd = cmd_q;
  assign request_valid = req_q;
  assign fp_exception = fpexc_q;
  assign maskable_interrupt_request = !lic_en_q && lint_s[0];
  assign nonmaskable_interrupt = !lic_en_q && lint_s[1];
  assign local_interrupt_out = lic_en_q ? lint_s : 2'b00;
  assign integer_reset = intrst_q;
  assign cache_invalidate = rst;
  assign builtin_self_test = builtin_self_test_q;
  assign core_ready = pgood_s && !rst && !priority_bus_request_s_unused();

  function automatic logic priority_bus_request_s_unused();
    priority_bus_request_s_unused = 1'b0 & priority_bus_request_s & async_sync[1] & async_sync[0];
  endfunction : priority_bus_request_s_unused

endmodule : sideband_control

// >>> sideband_control_asserts.sv
// Concurrent checks on the sideband control block, seen from its ports.
// Assumes one bus clock and a synchronous active-high reset; bound below.
`timescale 1ns/10ps
module sideband_control_asserts
  import sideband_pkg::*;
(
  input wire logic clk, // Bus clock
  input wire logic rst, // Reset
  input wire logic bus_init_request, // Pin
  input wire logic soft_init, // Pin
  input wire logic txn_start, // Core
  input wire logic [4:0] txn_cmd, // Core
  input wire logic internal_error_event, // Core
  input wire logic fp_insn_noncontrol, // Core
  input wire logic lock_begin, // Core
  input wire logic snoop_hit, // Out
  input wire logic snoop_hit_modified, // Out
  input wire logic internal_error_out, // Out
  input wire logic request_valid, // Out
  input wire logic [4:0] request_cmd, // Out
  input wire logic fp_exception, // Out
  input wire logic bus_atomic_hold // Out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Clears pass the pin synchronisers, so look back five cycles
  logic [4:0] clr_q;
  logic [4:0] clr_d;
  always_comb clr_d = {clr_q[3:0], rst | bus_init_request | soft_init};
  always_ff @(posedge clk) clr_q <= clr_d;
  sequence lock_open_s;
    lock_begin && txn_start;
  endsequence
  sequence reset_held_s;
    rst ##1 rst;
  endsequence
  hit_pair_a: assert property (snoop_hit == snoop_hit_modified)
    else $error("snoop hit pair split");
  internal_error_out_set_a: assert property (internal_error_event |=> internal_error_out)
    else $error("internal error not raised");
  internal_error_out_hold_a: assert property ($fell(internal_error_out) |-> |clr_q)
    else $error("internal error dropped without a clear");
  halt_cmd_a: assert property (internal_error_event |=>
    request_valid && request_cmd == REQ_CMD_HALT) else $error("halt request missing");
  req_echo_a: assert property (txn_start && !internal_error_event |=>
    request_valid && request_cmd == $past(txn_cmd)) else $error("request command wrong");
  fp_cause_a: assert property (!fp_insn_noncontrol |=> !fp_exception)
    else $error("fp exception without instruction");
  lock_hold_a: assert property (lock_open_s |=> bus_atomic_hold [*2])
    else $error("atomic hold missing");
  reset_quiet_a: assert property (disable iff (1'b0) reset_held_s |->
    !internal_error_out && !request_valid && !bus_atomic_hold) else $error("outputs in reset");
endmodule : sideband_control_asserts
bind sideband_control sideband_control_asserts u_sideband_control_asserts (.*);

// >>> chipset_model.sv
// Behavioural chipset side: supply-good sequencing and a priority bus agent.
// Assumes the bench raises want_bus when it needs the bus.
`timescale 1ns/10ps
module chipset_model #(
  parameter int PG_DELAY = 4
) (
  input wire logic clk, // Bus clock
  input wire logic bus_atomic_hold, // Atomic hold from the device
  input wire logic want_bus, // Bench asks for ownership
  output logic supply_stable_input, // Supply-good pin
  output logic priority_bus_request, // Priority request pin
  output logic owns_bus // Priority agent holds the bus
);
  int cnt = 0;
  initial
  begin
    supply_stable_input = 1'b0;
    priority_bus_request = 1'b0;
    owns_bus = 1'b0;
  end
  always @(posedge clk)
  begin
    cnt <= (cnt < PG_DELAY) ? cnt + 1 : cnt;
    // Low and clean until the count runs out, then rises once for good
    supply_stable_input <= (cnt >= PG_DELAY);
    priority_bus_request <= want_bus;
    owns_bus <= want_bus && priority_bus_request && !bus_atomic_hold;
  end
endmodule : chipset_model

// >>> sideband_control_tb.sv
// Self-checking bench for the sideband control block.
// Assumes the chipset model supplies supply-good and priority requests.
`timescale 1ns/10ps
module sideband_control_tb;
  import sideband_pkg::*;
  logic clk = 0, rst = 1, stop_clock_request = 0, probe_request = 0, ignore_numeric_error = 0;
  logic soft_init = 1, bus_init_request = 0, fp_error_detect = 0, fp_insn_noncontrol = 0;
  logic fp_error_pending = 0, numeric_error_enable_bit = 0, internal_error_event = 0;
  logic lic_enable_wr = 0, lic_enable_val = 1, snoop_request = 0, snoop_stall_need = 0;
  logic lock_begin = 0, lock_end = 0, txn_start = 0, temp_max_trip = 0, deep_sleep_state = 0;
  logic want_bus = 0;
  logic [1:0] local_interrupt_pins = 2'h0;
  logic [4:0] txn_cmd = 5'h00;
  logic supply_stable_input, priority_bus_request, owns_bus, fp_error_break_event_out;
  logic internal_error_out, snoop_hit, snoop_hit_modified, bus_atomic_hold, overtemperature_out;
  logic low_power_status_indicator, request_valid, fp_exception, maskable_interrupt_request;
  logic nonmaskable_interrupt, integer_reset, cache_invalidate, builtin_self_test, core_ready;
  logic [4:0] request_cmd;
  logic [1:0] local_interrupt_out;
  logic [4:0] exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int n;
  sideband_control u_sideband_control (.*);
  chipset_model u_chipset_model (.*);
  always #10 clk = ~clk;
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task wait_pulse(input logic sel);
    n = 0;
    while ((sel ? integer_reset : builtin_self_test) !== 1'b1 && n < 8)
    begin
      step(1);
      n++;
    end
    if (n == 8)
    begin
      num_errors++;
      give_verdict();
    end
  endtask : wait_pulse
  // Each cycle with request_valid high takes the oldest queued command; sampled mid-cycle, off the launch edge
  always @(negedge clk)
    if (request_valid === 1'b1)
      chk(request_cmd, exp_q.size() ? exp_q.pop_front() : ~request_cmd);
  initial
  begin
    #1000000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h6d5c14ed));
    // Reset hold kept short to bound the run; straps stand before release
    step(3);
    chk(cache_invalidate, 1);
    rst = 0;
    wait_pulse(0);
    chk(builtin_self_test, 1);
    snoop_request = 1;
    snoop_stall_need = 1;
    step(1);
    chk({snoop_hit, snoop_hit_modified}, 3);
    snoop_stall_need = 0;
    soft_init = 0;
    step(4);
    soft_init = 1;
    wait_pulse(1);
    chk(integer_reset, 1);
    soft_init = 0;
    local_interrupt_pins = 2'h3;
    step(3);
    chk({maskable_interrupt_request, nonmaskable_interrupt, local_interrupt_out}, 3);
    lic_enable_val = 0;
    lic_enable_wr = 1;
    step(1);
    lic_enable_wr = 0;
    for (int i = 1; i < 3; i++)
    begin
      local_interrupt_pins = i[1:0];
      step(3);
      chk({nonmaskable_interrupt, maskable_interrupt_request}, i[4:0]);
    end
    repeat (6)
    begin
      txn_cmd = 5'($urandom);
      exp_q.push_back(txn_cmd);
      txn_start = 1;
      step(1);
    end
    txn_start = 0;
    internal_error_event = 1;
    exp_q.push_back(REQ_CMD_HALT);
    step(1);
    internal_error_event = 0;
    step(5);
    chk(internal_error_out, 1);
    bus_init_request = 1;
    step(4);
    bus_init_request = 0;
    chk(internal_error_out, 0);
    for (int i = 0; i < 8; i++)
    begin
      // Ignore pin held steady from here until the instruction samples it
      {numeric_error_enable_bit, ignore_numeric_error, fp_error_pending} = i[2:0];
      step(3);
      fp_insn_noncontrol = 1;
      step(1);
      fp_insn_noncontrol = 0;
      chk(fp_exception, 5'(i[0] & (i[2] | !i[1])));
    end
    fp_error_detect = 1;
    step(2);
    chk(fp_error_break_event_out, 1);
    fp_error_detect = 0;
    stop_clock_request = 1;
    step(4);
    chk(fp_error_break_event_out, 0);
    probe_request = 1;
    step(4);
    probe_request = 0;
    step(6);
    chk(fp_error_break_event_out, 1);
    stop_clock_request = 0;
    step(4);
    chk(fp_error_break_event_out, 0);
    txn_cmd = REQ_CMD_LOCKED;
    exp_q.push_back(txn_cmd);
    lock_begin = 1;
    txn_start = 1;
    step(1);
    lock_begin = 0;
    txn_start = 0;
    want_bus = 1;
    step(6);
    chk({bus_atomic_hold, owns_bus}, 2);
    lock_end = 1;
    step(1);
    lock_end = 0;
    step(5);
    chk({bus_atomic_hold, owns_bus}, 1);
    temp_max_trip = 1;
    deep_sleep_state = 1;
    step(2);
    chk({overtemperature_out, low_power_status_indicator, core_ready}, 7);
    internal_error_event = 1;
    exp_q.push_back(REQ_CMD_HALT);
    step(1);
    internal_error_event = 0;
    rst = 1;
    step(2);
    chk({internal_error_out, request_valid, bus_atomic_hold, cache_invalidate}, 1);
    rst = 0;
    step(3);
    chk(5'(exp_q.size()), 5'h00);
    give_verdict();
  end
endmodule : sideband_control_tb
